// File: verilog/mbrf_pkg.sv
// constants and carrier types for the mode banked register file
package mbrf_pkg;

  // ==========================================================================
  // mode numbers
  typedef enum logic [4:0] {
    MBRF_MODE_USR = 5'h10,
    MBRF_MODE_FIQ = 5'h11,
    MBRF_MODE_IRQ = 5'h12,
    MBRF_MODE_SVC = 5'h13,
    MBRF_MODE_ABT = 5'h17,
    MBRF_MODE_UND = 5'h1b,
    MBRF_MODE_SYS = 5'h1f
  } mbrf_mode_t;

  // ==========================================================================
  // exception kinds and access sizes
  typedef enum logic [2:0] {
    MBRF_EXC_FIQ = 3'h0,
    MBRF_EXC_IRQ = 3'h1,
    MBRF_EXC_SVC = 3'h2,
    MBRF_EXC_ABT = 3'h3,
    MBRF_EXC_UND = 3'h4
  } mbrf_exc_t;

  typedef enum logic [1:0] {
    MBRF_SIZE_BYTE = 2'h0,
    MBRF_SIZE_HALF = 2'h1,
    MBRF_SIZE_WORD = 2'h2
  } mbrf_size_t;

  // ==========================================================================
  // register file geometry and reset values
  localparam int unsigned MBRF_NUM_GPR      = 31;
  localparam int unsigned MBRF_NUM_PSR      = 6;
  localparam int unsigned MBRF_DATA_W       = 32;
  localparam logic [3:0]  MBRF_IDX_PC       = 4'hf;
  localparam logic [3:0]  MBRF_IDX_LINK     = 4'he;
  localparam logic [4:0]  MBRF_PHYS_FIQ_R8  = 5'h10;
  localparam logic [4:0]  MBRF_PHYS_EXC_R13 = 5'h15;
  localparam logic [31:0] MBRF_STATUS_RST   = 32'h0000_0013;
  localparam logic [31:0] MBRF_CTRL_MASK    = 32'h0000_00ff;
  localparam logic [31:0] MBRF_MODE_MASK    = 32'h0000_001f;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       en;
    logic [3:0] idx;
    mbrf_size_t size;
    logic [31:0] data;
  } mbrf_wr_req_t;

  typedef struct packed {
    logic        en;
    logic [31:0] data;
  } mbrf_psr_req_t;

  typedef struct packed {
    logic        valid;
    mbrf_exc_t   kind;
    logic [31:0] link;
  } mbrf_exc_req_t;

  typedef struct packed {
    logic        valid;
    logic        compressed;
    logic [31:0] addr;
  } mbrf_fetch_req_t;

  typedef struct packed {
    logic [30:0][31:0] gpr;
    logic [5:0][31:0]  psr;
    logic [31:0]       rd_a;
    logic [31:0]       rd_b;
    logic [31:0]       saved;
    logic              saved_vis;
    logic              priv;
    logic              refused;
    logic              misalign;
  } mbrf_state_t;

endpackage

// File: verilog/mbrf_core.sv
// mode control and mode banked register file of the core
`timescale 1ns/1ps

module mbrf_core
  import mbrf_pkg::*;
#(
  parameter logic [31:0] PSR_IMPL_MASK = 32'hffff_ffff
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_resetn,
  input  wire logic [3:0]      i_rd_a_idx,
  input  wire logic [3:0]      i_rd_b_idx,
  input  wire mbrf_wr_req_t    i_wr,
  input  wire mbrf_psr_req_t   i_psr_wr,
  input  wire mbrf_exc_req_t   i_exc,
  input  wire mbrf_fetch_req_t i_fetch,
  output logic [31:0]          o_rd_a_data,
  output logic [31:0]          o_rd_b_data,
  output logic [31:0]          o_current_status_reg,
  output logic [4:0]           o_mode,
  output logic [31:0]          o_saved_status_reg,
  output logic                 o_saved_status_valid,
  output logic                 o_privileged,
  output logic                 o_mode_refused,
  output logic                 o_fetch_misaligned
);

  // ==========================================================================
  // elaboration checks
  if ((PSR_IMPL_MASK & MBRF_CTRL_MASK) != MBRF_CTRL_MASK) begin : g_bad_mask
    $error("mbrf_core: status mask must keep the control byte");
  end

  // ==========================================================================
  // mode decode helpers
  function automatic logic mode_legal(input logic [4:0] m);
    return m inside {MBRF_MODE_USR, MBRF_MODE_FIQ, MBRF_MODE_IRQ, MBRF_MODE_SVC,
                     MBRF_MODE_ABT, MBRF_MODE_UND, MBRF_MODE_SYS};
  endfunction

  // bank 0 serves user and system, 1..5 the exception modes
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    logic [2:0] b;
    b = 3'h0;
    unique case (m)
      MBRF_MODE_FIQ: b = 3'h1;
      MBRF_MODE_IRQ: b = 3'h2;
      MBRF_MODE_SVC: b = 3'h3;
      MBRF_MODE_ABT: b = 3'h4;
      MBRF_MODE_UND: b = 3'h5;
      default:       b = 3'h0;
    endcase
    return b;
  endfunction

  function automatic logic [4:0] exc_mode(input mbrf_exc_t k);
    logic [4:0] m;
    m = MBRF_MODE_SVC;
    unique case (k)
      MBRF_EXC_FIQ: m = MBRF_MODE_FIQ;
      MBRF_EXC_IRQ: m = MBRF_MODE_IRQ;
      MBRF_EXC_SVC: m = MBRF_MODE_SVC;
      MBRF_EXC_ABT: m = MBRF_MODE_ABT;
      MBRF_EXC_UND: m = MBRF_MODE_UND;
      default:      m = MBRF_MODE_SVC;
    endcase
    return m;
  endfunction

  // physical slot: 0-14 shared/user, 15 pc, 16-20 fast r8-r12, 21-30 r13/r14
  function automatic logic [4:0] phys_of(input logic [3:0] idx, input logic [4:0] m);
    logic [2:0] b;
    logic [4:0] p;
    b = bank_of(m);
    p = {1'b0, idx};
    if (idx >= 4'h8 && idx <= 4'hc && b == 3'h1) begin
      p = 5'(MBRF_PHYS_FIQ_R8 + {1'b0, idx} - 5'h08);
    end else if ((idx == 4'hd || idx == MBRF_IDX_LINK) && b != 3'h0) begin
      p = 5'(MBRF_PHYS_EXC_R13 + {b - 3'h1, 1'b0} + {4'h0, idx[0] ^ 1'b1});
    end
    return p;
  endfunction

  function automatic logic [31:0] sized(input mbrf_size_t s, input logic [31:0] v);
    logic [31:0] r;
    r = v;
    unique case (s)
      MBRF_SIZE_BYTE: r = {24'h0, v[7:0]};
      MBRF_SIZE_HALF: r = {16'h0, v[15:0]};
      default:        r = v;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // state
  mbrf_state_t q;
  mbrf_state_t d;
  logic [4:0]  cur_mode;
  logic [4:0]  new_mode;
  logic [4:0]  tgt_mode;
  logic [2:0]  new_bank;
  logic [31:0] impl_mask;

  assign impl_mask = PSR_IMPL_MASK;
  assign cur_mode  = q.psr[0][4:0];

  always_comb begin
    d        = q;
    d.refused = 1'b0;
    tgt_mode = exc_mode(i_exc.kind);
    // reads see the state before this cycle's writes
    d.rd_a = q.gpr[phys_of(i_rd_a_idx, cur_mode)];
    d.rd_b = q.gpr[phys_of(i_rd_b_idx, cur_mode)];
    if (i_wr.en) begin
      d.gpr[phys_of(i_wr.idx, cur_mode)] = sized(i_wr.size, i_wr.data);
    end
    if (i_psr_wr.en) begin
      if (cur_mode != MBRF_MODE_USR) begin
        if (mode_legal(i_psr_wr.data[4:0])) begin
          d.psr[0] = i_psr_wr.data & impl_mask;
        end else begin
          d.refused = 1'b1;
        end
      end else begin
        // user keeps its control byte; only upper bits may change
        d.psr[0] = (i_psr_wr.data & impl_mask & ~MBRF_CTRL_MASK) |
                   (q.psr[0] & MBRF_CTRL_MASK);
        d.refused = (i_psr_wr.data[4:0] != cur_mode);
      end
    end
    // exception entry wins over a same cycle status write
    if (i_exc.valid && i_exc.kind <= MBRF_EXC_UND) begin
      d.psr[bank_of(tgt_mode)] = q.psr[0];
      d.psr[0] = (q.psr[0] & ~MBRF_MODE_MASK) | {27'h0, tgt_mode};
      d.gpr[phys_of(MBRF_IDX_LINK, tgt_mode)] = i_exc.link;
    end
    new_mode   = d.psr[0][4:0];
    new_bank   = bank_of(new_mode);
    d.priv      = (new_mode != MBRF_MODE_USR);
    d.saved_vis = (new_bank != 3'h0);
    d.saved     = (new_bank != 3'h0) ? d.psr[new_bank] : 32'h0;
    d.misalign = i_fetch.valid &
                 (i_fetch.compressed ? i_fetch.addr[0] : |i_fetch.addr[1:0]);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q           <= '0;
      q.psr[0]    <= MBRF_STATUS_RST;
      q.priv      <= 1'b1;
      q.saved_vis <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rd_a_data          = q.rd_a;
  assign o_rd_b_data          = q.rd_b;
  assign o_current_status_reg = q.psr[0];
  assign o_mode               = q.psr[0][4:0];
  assign o_saved_status_reg   = q.saved;
  assign o_saved_status_valid = q.saved_vis;
  assign o_privileged         = q.priv;
  assign o_mode_refused       = q.refused;
  assign o_fetch_misaligned   = q.misalign;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_user_code;
    i_psr_wr.en && o_privileged && !i_exc.valid && i_psr_wr.data[4:0] == 5'h10
      |=> o_mode == 5'h10 && !o_privileged;
  endproperty
  a_user_code: assert property (p_user_code) else $error("user mode number wrong");

  property p_fiq_entry;
    i_exc.valid && i_exc.kind == MBRF_EXC_FIQ |=> o_mode == 5'h11;
  endproperty
  a_fiq_entry: assert property (p_fiq_entry) else $error("fast entry mode wrong");

  property p_irq_entry;
    i_exc.valid && i_exc.kind == MBRF_EXC_IRQ |=> o_mode == 5'h12;
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("irq entry mode wrong");

  property p_svc_entry;
    i_exc.valid && i_exc.kind == MBRF_EXC_SVC |=> o_mode == 5'h13;
  endproperty
  a_svc_entry: assert property (p_svc_entry) else $error("svc entry mode wrong");

  property p_abt_entry;
    i_exc.valid && i_exc.kind == MBRF_EXC_ABT |=> o_mode == 5'h17;
  endproperty
  a_abt_entry: assert property (p_abt_entry) else $error("abort entry mode wrong");

  property p_und_entry;
    i_exc.valid && i_exc.kind == MBRF_EXC_UND |=> o_mode == 5'h1b;
  endproperty
  a_und_entry: assert property (p_und_entry) else $error("undef entry mode wrong");

  property p_sys_code;
    i_psr_wr.en && o_privileged && !i_exc.valid && i_psr_wr.data[4:0] == 5'h1f
      |=> o_mode == 5'h1f && o_privileged && !o_saved_status_valid;
  endproperty
  a_sys_code: assert property (p_sys_code) else $error("system mode number wrong");

  property p_user_locked;
    o_mode == 5'h10 && !i_exc.valid
      |=> o_mode == 5'h10 && $stable(o_current_status_reg[7:0]);
  endproperty
  a_user_locked: assert property (p_user_locked) else $error("user left mode");

  property p_user_refused;
    o_mode == 5'h10 && i_psr_wr.en && i_psr_wr.data[4:0] != 5'h10 |=> o_mode_refused;
  endproperty
  a_user_refused: assert property (p_user_refused) else $error("no refusal");

  property p_no_sys_exc;
    i_exc.valid && i_exc.kind <= MBRF_EXC_UND |=> o_mode != 5'h1f && o_privileged;
  endproperty
  a_no_sys_exc: assert property (p_no_sys_exc) else $error("exception entered system");

  property p_status_save;
    i_exc.valid && i_exc.kind <= MBRF_EXC_UND
      |=> o_saved_status_valid && o_saved_status_reg == $past(o_current_status_reg);
  endproperty
  a_status_save: assert property (p_status_save) else $error("status not saved");

  property p_low_shared;
    (i_wr.en && i_wr.idx < 4'h8 && i_wr.size == MBRF_SIZE_WORD) ##1
      (i_rd_a_idx == $past(i_wr.idx) && !(i_wr.en && i_wr.idx == $past(i_wr.idx)))
      |=> o_rd_a_data == $past(i_wr.data, 2);
  endproperty
  a_low_shared: assert property (p_low_shared) else $error("low index banked");

  property p_word_align;
    i_fetch.valid && !i_fetch.compressed && i_fetch.addr[1:0] != 2'h0
      |=> o_fetch_misaligned;
  endproperty
  a_word_align: assert property (p_word_align) else $error("misaligned fetch missed");

  property p_half_align;
    i_fetch.valid && i_fetch.compressed && !i_fetch.addr[0] |=> !o_fetch_misaligned;
  endproperty
  a_half_align: assert property (p_half_align) else $error("halfword fetch flagged");

  property p_refused_illegal;
    o_privileged && i_psr_wr.en && !i_exc.valid && !mode_legal(i_psr_wr.data[4:0])
      |=> o_mode_refused && $stable(o_current_status_reg);
  endproperty
  a_refused_illegal: assert property (p_refused_illegal) else $error("bad mode taken");

  property p_refused_idle;
    !i_psr_wr.en |=> !o_mode_refused;
  endproperty
  a_refused_idle: assert property (p_refused_idle) else $error("refusal without write");

  property p_priv_match;
    o_privileged == (o_mode != 5'h10);
  endproperty
  a_priv_match: assert property (p_priv_match) else $error("privilege flag wrong");

  property p_saved_vis;
    o_saved_status_valid == (o_mode != 5'h10 && o_mode != 5'h1f);
  endproperty
  a_saved_vis: assert property (p_saved_vis) else $error("saved status visibility wrong");

  property p_saved_zero;
    !o_saved_status_valid |-> o_saved_status_reg == 32'h0;
  endproperty
  a_saved_zero: assert property (p_saved_zero) else $error("saved status shown in user");

  property p_mode_legal;
    mode_legal(o_mode);
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal current mode");

  property p_exc_upper;
    i_exc.valid && i_exc.kind <= MBRF_EXC_UND
      |=> o_current_status_reg[31:5] == $past(o_current_status_reg[31:5]);
  endproperty
  a_exc_upper: assert property (p_exc_upper) else $error("entry changed status bits");

  property p_exc_priv;
    i_exc.valid && i_exc.kind <= MBRF_EXC_UND |=> o_privileged && o_saved_status_valid;
  endproperty
  a_exc_priv: assert property (p_exc_priv) else $error("entry not privileged");

  property p_user_upper;
    o_mode == 5'h10 && i_psr_wr.en && !i_exc.valid
      |=> o_current_status_reg[31:8] == ($past(i_psr_wr.data[31:8]) & PSR_IMPL_MASK[31:8]);
  endproperty
  a_user_upper: assert property (p_user_upper) else $error("user status bits lost");

  property p_exc_link;
    (i_exc.valid && i_exc.kind <= MBRF_EXC_UND) ##1
      (i_rd_a_idx == MBRF_IDX_LINK && !i_wr.en && !i_exc.valid)
      |=> o_rd_a_data == $past(i_exc.link, 2);
  endproperty
  a_exc_link: assert property (p_exc_link) else $error("link not in target bank");

  property p_fetch_idle;
    !i_fetch.valid |=> !o_fetch_misaligned;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("misaligned without fetch");

  property p_word_ok;
    i_fetch.valid && !i_fetch.compressed && i_fetch.addr[1:0] == 2'h0
      |=> !o_fetch_misaligned;
  endproperty
  a_word_ok: assert property (p_word_ok) else $error("aligned word fetch flagged");

  property p_half_odd;
    i_fetch.valid && i_fetch.compressed && i_fetch.addr[0] |=> o_fetch_misaligned;
  endproperty
  a_half_odd: assert property (p_half_odd) else $error("odd halfword fetch missed");

endmodule

// File: dv/mbrf_core_tb.sv
// self-checking bench for the mode banked register file
`timescale 1ns/1ps

module mbrf_core_tb;
  import mbrf_pkg::*;

  // ==========================================================================
  // clock, reset, design
  logic            i_sys_clk;
  logic            i_resetn;
  logic [3:0]      i_rd_a_idx;
  logic [3:0]      i_rd_b_idx;
  mbrf_wr_req_t    i_wr;
  mbrf_psr_req_t   i_psr_wr;
  mbrf_exc_req_t   i_exc;
  mbrf_fetch_req_t i_fetch;
  logic [31:0]     o_rd_a_data;
  logic [31:0]     o_rd_b_data;
  logic [31:0]     o_current_status_reg;
  logic [4:0]      o_mode;
  logic [31:0]     o_saved_status_reg;
  logic            o_saved_status_valid;
  logic            o_privileged;
  logic            o_mode_refused;
  logic            o_fetch_misaligned;
  int              n_errors;
  int              compares;
  int              cycles;

  mbrf_core u_mbrf_core (
    .i_sys_clk            (i_sys_clk),
    .i_resetn             (i_resetn),
    .i_rd_a_idx           (i_rd_a_idx),
    .i_rd_b_idx           (i_rd_b_idx),
    .i_wr                 (i_wr),
    .i_psr_wr             (i_psr_wr),
    .i_exc                (i_exc),
    .i_fetch              (i_fetch),
    .o_rd_a_data          (o_rd_a_data),
    .o_rd_b_data          (o_rd_b_data),
    .o_current_status_reg (o_current_status_reg),
    .o_mode               (o_mode),
    .o_saved_status_reg   (o_saved_status_reg),
    .o_saved_status_valid (o_saved_status_valid),
    .o_privileged         (o_privileged),
    .o_mode_refused       (o_mode_refused),
    .o_fetch_misaligned   (o_fetch_misaligned)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // hang guard, well above the run length
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    i_rd_a_idx = idx;
    i_rd_b_idx = idx;
    @(negedge i_sys_clk);
    chk("rd_a", o_rd_a_data, exp);
    chk("rd_b", o_rd_b_data, exp);
  endtask

  task automatic wr(input logic [3:0] idx, input mbrf_size_t sz, input logic [31:0] d);
    i_wr = '{en: 1'b1, idx: idx, size: sz, data: d};
    @(negedge i_sys_clk);
    i_wr.en = 1'b0;
  endtask

  // status write, then state and refusal pulse in the following cycle
  task automatic psr(input logic [31:0] d, input logic [4:0] m, input logic refused);
    i_psr_wr = '{en: 1'b1, data: d};
    @(negedge i_sys_clk);
    i_psr_wr.en = 1'b0;
    chk("mode", o_mode, m);
    chk("refused", o_mode_refused, refused);
    chk("priv", o_privileged, m != MBRF_MODE_USR);
    chk("saved_valid", o_saved_status_valid, m != MBRF_MODE_USR && m != MBRF_MODE_SYS);
    @(negedge i_sys_clk);
  endtask

  task automatic exc(input mbrf_exc_t k, input logic [31:0] link, input logic [4:0] m);
    logic [31:0] old;
    old = o_current_status_reg;
    i_exc = '{valid: 1'b1, kind: k, link: link};
    @(negedge i_sys_clk);
    i_exc.valid = 1'b0;
    chk("exc_mode", o_mode, m);
    chk("exc_saved", o_saved_status_reg, old);
    chk("exc_status", o_current_status_reg, {old[31:5], m});
    chk("exc_priv", o_privileged, 1'b1);
    rd(MBRF_IDX_LINK, link);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("rst_status", o_current_status_reg, MBRF_STATUS_RST);
    chk("rst_saved", o_saved_status_reg, 32'h0000_0000);
    chk("rst_priv", o_privileged, 1'b1);
    chk("rst_saved_valid", o_saved_status_valid, 1'b1);
    rd(4'h3, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_sizes();
    wr(4'h5, MBRF_SIZE_WORD, 32'hdead_beef);
    rd(4'h5, 32'hdead_beef);
    wr(4'h5, MBRF_SIZE_BYTE, 32'h1234_5678);
    rd(4'h5, 32'h0000_0078);
    wr(4'h5, MBRF_SIZE_HALF, 32'h1234_5678);
    rd(4'h5, 32'h0000_5678);
    $display("test sizes done");
  endtask

  task automatic t_modes();
    logic [4:0] codes [7];
    codes = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f, 5'h10};
    for (int i = 0; i < 7; i++) begin
      psr({27'h0, codes[i]}, codes[i], 1'b0);
      if (i == 5) begin
        psr(32'h0000_0015, 5'h1f, 1'b1);
      end
    end
    psr(32'h0000_001f, 5'h10, 1'b1);
    psr(32'hf000_0010, 5'h10, 1'b0);
    chk("user_status", o_current_status_reg, 32'hf000_0010);
    exc(MBRF_EXC_SVC, 32'h0000_0c0c, 5'h13);
    $display("test modes done");
  endtask

  task automatic t_banks();
    psr(32'h0000_001f, 5'h1f, 1'b0);
    for (int i = 0; i < 15; i++) begin
      wr(4'(i), MBRF_SIZE_WORD, 32'h100 + i);
      @(negedge i_sys_clk);
    end
    exc(MBRF_EXC_FIQ, 32'h0000_00a5, 5'h11);
    for (int i = 0; i < 14; i++) begin
      rd(4'(i), (i < 8) ? 32'h100 + i : 32'h0);
    end
    wr(4'h8, MBRF_SIZE_WORD, 32'h0000_00f8);
    rd(4'h8, 32'h0000_00f8);
    exc(MBRF_EXC_IRQ, 32'h0000_00b6, 5'h12);
    rd(4'h8, 32'h0000_0108);
    rd(4'hd, 32'h0000_0000);
    psr(32'h0000_001f, 5'h1f, 1'b0);
    for (int i = 8; i < 15; i++) begin
      rd(4'(i), 32'h100 + i);
    end
    psr(32'h0000_0010, 5'h10, 1'b0);
    rd(4'he, 32'h0000_010e);
    $display("test banks done");
  endtask

  task automatic t_exc_kinds();
    logic [4:0] want [5];
    want = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b};
    for (int k = 0; k < 5; k++) begin
      exc(mbrf_exc_t'(k), 32'h2000 + k, want[k]);
      rd(4'hd, 32'h0000_0000);
      wr(4'hd, MBRF_SIZE_WORD, 32'h3000 + k);
    end
    i_exc = '{valid: 1'b1, kind: mbrf_exc_t'(3'h5), link: 32'h0};
    @(negedge i_sys_clk);
    i_exc.valid = 1'b0;
    chk("kind5_mode", o_mode, 5'h1b);
    psr(32'h0000_0013, 5'h13, 1'b0);
    rd(4'hd, 32'h0000_3002);
    $display("test exception kinds done");
  endtask

  task automatic t_fetch();
    logic [31:0] addr [6];
    logic        comp [6];
    logic        bad  [6];
    addr = '{32'h0, 32'h2, 32'h1, 32'h6, 32'h3, 32'h4};
    comp = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    bad  = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      i_fetch = '{valid: 1'b1, compressed: comp[i], addr: addr[i]};
      @(negedge i_sys_clk);
      chk("misaligned", o_fetch_misaligned, bad[i]);
    end
    i_fetch.valid = 1'b0;
    @(negedge i_sys_clk);
    chk("misaligned_idle", o_fetch_misaligned, 1'b0);
    $display("test fetch done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_rd_a_idx = 4'h0;
    i_rd_b_idx = 4'h0;
    i_wr = '0;
    i_psr_wr = '0;
    i_exc = '0;
    i_fetch = '0;
    repeat (16) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    t_reset();
    t_sizes();
    t_modes();
    t_banks();
    t_exc_kinds();
    t_fetch();
    tally_and_finish();
  end

endmodule
